// ### hw/calib_readout_pkg.sv
// package: constants and carriers for the leveling-exit and calibration readout block
// assumes one core clock, commands already decoded from the pins upstream
//
// Notes on behaviour
// - feedback on prime pin, others held low unless FEEDBACK_ALL set
// - data pins undefined until update delay passes
// - mode gap then update delay before commands; code gates commands on the update delay only
// - third register bit 2 toggles readout mode
// - reads redirected to pattern register in mode
// - auto close read acts as plain read
// - reset still honoured in readout mode
// - bit 0 carries data, others copy or zero
// - chopped read: bit 2 selects nibble
// - bank, column high and misc bits ignored
// - bit 12 picks on-the-fly chop if enabled
// - normal read latency, locked loop required
// - beat 0 is lsb, beat 7 msb
// - location 0 gives alternating pattern; rest reserved
// - bit 2 clear means normal array operation
// - first register bit 7 controls leveling mode
package calib_readout_pkg;

   localparam int          MODE_CMD_GAP_CK    = 4;
   localparam int          MODE_UPDATE_NS     = 15;
   localparam int          CORE_PERIOD_NS     = 4;
   localparam int          MODE_UPDATE_CYC    = (MODE_UPDATE_NS + CORE_PERIOD_NS - 1)
                                                / CORE_PERIOD_NS;
   localparam int          BEATS_EIGHT        = 8;
   localparam int          BEATS_FOUR         = 4;
   localparam logic [1:0]  REG_SEL_ONE        = 2'h1;
   localparam logic [1:0]  REG_SEL_THREE      = 2'h3;
   localparam int          LEVEL_EN_BIT       = 7;
   localparam int          READOUT_EN_BIT     = 2;
   localparam int          CHOP_SELECT_BIT    = 12;
   localparam int          NIBBLE_BIT         = 2;
   localparam logic [1:0]  LOC_PATTERN        = 2'h0;
   localparam logic [7:0]  PATTERN_BITS       = 8'hAA;
   localparam logic [1:0]  CHOP_FIXED_EIGHT   = 2'h0;
   localparam logic [1:0]  CHOP_ON_THE_FLY    = 2'h1;
   localparam logic [1:0]  CHOP_FIXED_FOUR    = 2'h2;

   typedef struct packed {
      logic        valid;
      logic        mode_set;
      logic        read;
      logic        read_auto_close;
      logic        write;
      logic [1:0]  reg_sel;
      logic [14:0] addr;
   } cmd_type;

   typedef struct packed {
      logic        level_on;
      logic        readout_on;
      logic [1:0]  loc_sel;
      logic [1:0]  chop_mode;
      logic [7:0]  gap_cnt;
      logic [7:0]  upd_cnt;
      logic [7:0]  lat_cnt;
      logic        lat_pend;
      logic        pend_four;
      logic        pend_upper;
      logic [3:0]  beat_cnt;
      logic [2:0]  beat_idx;
      logic        lower_bit;
      logic        upper_bit;
      logic        dq_oe;
      logic        undefined_state;
      logic        array_read;
      logic        array_write;
      logic        skip_precharge;
      logic        cmd_ok;
      logic        fb_lower;
      logic        fb_upper;
   } state_type;

endpackage

// ### hw/calib_readout.sv
// module: leveling feedback, leveling exit tracking and calibration pattern readout
// assumes decoded commands and strobe samples are already on core_clk
`timescale 1ns/10ps

module calib_readout #(
   parameter int READ_LATENCY = 6,
   parameter bit FEEDBACK_ALL = 1'b0,
   parameter bit COPY_UPPER   = 1'b1
) (
   input  wire logic                        core_clk,
   input  wire logic                        arst_n,
   input  wire calib_readout_pkg::cmd_type  cmd,
   input  wire logic                        lower_strobe_pin,
   input  wire logic                        upper_strobe_pin,
   input  wire logic                        lower_clk_sample,
   input  wire logic                        upper_clk_sample,
   output logic [7:0]                       lower_lane_data,
   output logic [7:0]                       upper_lane_data,
   output logic                             lane_data_oe,
   output logic                             data_undefined,
   output logic                             level_mode,
   output logic                             readout_mode,
   output logic                             array_read,
   output logic                             array_write,
   output logic                             skip_auto_close,
   output logic                             cmd_allowed
);

   initial
   begin
      if (READ_LATENCY < 1 || READ_LATENCY > 200)
         $error("read latency out of range");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage feeds only the second

   logic [3:0] pin_s1_r;
   logic [3:0] pin_s2_r;
   logic       lower_strobe_prev_r;
   logic       upper_strobe_prev_r;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_s1_r            <= 4'h0;
         pin_s2_r            <= 4'h0;
         lower_strobe_prev_r <= 1'b0;
         upper_strobe_prev_r <= 1'b0;
      end
      else
      begin
         pin_s1_r            <= {upper_clk_sample, lower_clk_sample,
                                 upper_strobe_pin, lower_strobe_pin};
         pin_s2_r            <= pin_s1_r;
         lower_strobe_prev_r <= pin_s2_r[0];
         upper_strobe_prev_r <= pin_s2_r[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state

   calib_readout_pkg::state_type st_r;
   calib_readout_pkg::state_type st_nxt;

   logic lower_rise;
   logic upper_rise;
   logic is_read;
   logic chop;
   logic [7:0] sel_bits;

   assign lower_rise = pin_s2_r[0] && !lower_strobe_prev_r;
   assign upper_rise = pin_s2_r[1] && !upper_strobe_prev_r;
   assign is_read    = cmd.valid && (cmd.read || cmd.read_auto_close);

   // reserved locations return zeros; only the pattern location is defined
   assign sel_bits = (st_r.loc_sel == calib_readout_pkg::LOC_PATTERN) ?
                     calib_readout_pkg::PATTERN_BITS : 8'h00;

   always_comb
   begin
      st_nxt                = st_r;
      st_nxt.array_read     = 1'b0;
      st_nxt.array_write    = 1'b0;
      st_nxt.skip_precharge = 1'b0;
      chop                  = 1'b0;

      if (st_r.gap_cnt != 8'h00)
         st_nxt.gap_cnt = st_r.gap_cnt - 8'h01;
      if (st_r.upd_cnt != 8'h00)
         st_nxt.upd_cnt = st_r.upd_cnt - 8'h01;

      // strobe feedback: sampled clock level at each rising strobe edge
      if (st_r.level_on)
      begin
         if (lower_rise)
            st_nxt.fb_lower = pin_s2_r[2];
         if (upper_rise)
            st_nxt.fb_upper = pin_s2_r[3];
      end

      if (cmd.valid && cmd.mode_set)
      begin
         st_nxt.gap_cnt = 8'(calib_readout_pkg::MODE_CMD_GAP_CK);
         st_nxt.upd_cnt = 8'(calib_readout_pkg::MODE_UPDATE_CYC);
         if (cmd.reg_sel == calib_readout_pkg::REG_SEL_ONE)
         begin
            st_nxt.level_on = cmd.addr[calib_readout_pkg::LEVEL_EN_BIT];
            if (st_r.level_on && !cmd.addr[calib_readout_pkg::LEVEL_EN_BIT])
               st_nxt.undefined_state = 1'b1;
         end
         else if (cmd.reg_sel == calib_readout_pkg::REG_SEL_THREE)
         begin
            st_nxt.readout_on = cmd.addr[calib_readout_pkg::READOUT_EN_BIT];
            st_nxt.loc_sel    = cmd.addr[1:0];
         end
         else if (cmd.reg_sel == 2'h0)
            st_nxt.chop_mode = cmd.addr[1:0];
      end

      if (is_read && st_r.readout_on)
      begin
         // bank, column above bit 2 and bits 11,13,14 unused; auto close only skips the precharge
         if (st_r.chop_mode == calib_readout_pkg::CHOP_FIXED_FOUR)
            chop = 1'b1;
         else if (st_r.chop_mode == calib_readout_pkg::CHOP_ON_THE_FLY)
            chop = !cmd.addr[calib_readout_pkg::CHOP_SELECT_BIT];
         st_nxt.skip_precharge = cmd.read_auto_close;
         st_nxt.lat_pend       = 1'b1;
         st_nxt.lat_cnt        = 8'(READ_LATENCY - 1);
         st_nxt.pend_four      = chop;
         st_nxt.pend_upper     = chop && cmd.addr[calib_readout_pkg::NIBBLE_BIT];
      end
      else if (is_read)
         st_nxt.array_read = 1'b1;

      if (cmd.valid && cmd.write && !st_r.readout_on)
         st_nxt.array_write = 1'b1;

      if (st_r.lat_pend)
      begin
         if (st_r.lat_cnt != 8'h00)
            st_nxt.lat_cnt = st_r.lat_cnt - 8'h01;
         else
         begin
            st_nxt.lat_pend = 1'b0;
            st_nxt.beat_cnt = st_r.pend_four ? 4'(calib_readout_pkg::BEATS_FOUR)
                                             : 4'(calib_readout_pkg::BEATS_EIGHT);
            st_nxt.beat_idx = st_r.pend_upper ? 3'h4 : 3'h0;
         end
      end

      if (st_r.beat_cnt != 4'h0)
      begin
         st_nxt.beat_cnt = st_r.beat_cnt - 4'h1;
         st_nxt.beat_idx = st_r.beat_idx + 3'h1;
      end

      // output selection
      st_nxt.dq_oe = 1'b0;
      if (st_r.beat_cnt != 4'h0)
      begin
         st_nxt.dq_oe     = 1'b1;
         st_nxt.lower_bit = sel_bits[st_r.beat_idx];
         st_nxt.upper_bit = sel_bits[st_r.beat_idx];
      end
      else if (st_r.level_on)
      begin
         st_nxt.dq_oe     = 1'b1;
         st_nxt.lower_bit = st_r.fb_lower;
         st_nxt.upper_bit = st_r.fb_upper;
      end

      // lanes become defined in the same cycle that commands become legal
      if (st_nxt.upd_cnt == 8'h00)
         st_nxt.undefined_state = 1'b0;

      // commands legal once update delay passed; mode sets too, gap_cnt gates nothing
      st_nxt.cmd_ok = (st_nxt.upd_cnt == 8'h00);
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output registers: data lanes per bit

   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_lane
         always_ff @(posedge core_clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               lower_lane_data[g] <= 1'b0;
               upper_lane_data[g] <= 1'b0;
            end
            else if (g == 0)
            begin
               lower_lane_data[g] <= st_nxt.lower_bit && st_nxt.dq_oe;
               upper_lane_data[g] <= st_nxt.upper_bit && st_nxt.dq_oe;
            end
            else if (st_r.beat_cnt != 4'h0)
            begin
               lower_lane_data[g] <= COPY_UPPER && st_nxt.lower_bit;
               upper_lane_data[g] <= COPY_UPPER && st_nxt.upper_bit;
            end
            else
            begin
               // non-prime pins held low in leveling outside readout bursts unless FEEDBACK_ALL is set
               lower_lane_data[g] <= FEEDBACK_ALL && st_nxt.lower_bit && st_nxt.dq_oe;
               upper_lane_data[g] <= FEEDBACK_ALL && st_nxt.upper_bit && st_nxt.dq_oe;
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lane_data_oe    <= 1'b0;
         data_undefined  <= 1'b0;
         level_mode      <= 1'b0;
         readout_mode    <= 1'b0;
         array_read      <= 1'b0;
         array_write     <= 1'b0;
         skip_auto_close <= 1'b0;
         cmd_allowed     <= 1'b0;
      end
      else
      begin
         lane_data_oe    <= st_nxt.dq_oe;
         data_undefined  <= st_nxt.undefined_state;
         level_mode      <= st_nxt.level_on;
         readout_mode    <= st_nxt.readout_on;
         array_read      <= st_nxt.array_read;
         array_write     <= st_nxt.array_write;
         skip_auto_close <= st_nxt.skip_precharge;
         cmd_allowed     <= st_nxt.cmd_ok;
      end
   end

endmodule

// ### tb/calib_readout_sva.sv
// checker: port timing of the leveling exit and calibration readout block
// assumes one clock domain; bound to every calib_readout instance
`timescale 1ns/10ps
module calib_readout_sva #(
   parameter int READ_LATENCY = 6,
   parameter bit FEEDBACK_ALL = 1'b0,
   parameter bit COPY_UPPER   = 1'b1
) (
   input wire logic                       core_clk,
   input wire logic                       arst_n,
   input wire calib_readout_pkg::cmd_type cmd,
   input wire logic [7:0]                 lower_lane_data,
   input wire logic [7:0]                 upper_lane_data,
   input wire logic                       lane_data_oe,
   input wire logic                       data_undefined,
   input wire logic                       level_mode,
   input wire logic                       readout_mode,
   input wire logic                       array_read,
   input wire logic                       array_write,
   input wire logic                       skip_auto_close,
   input wire logic                       cmd_allowed
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   logic [31:0] rd_pipe_r;
   logic [2:0]  beat_r;
   logic [1:0]  loc_r;
   wire ms = cmd.valid && cmd.mode_set;
   wire rd = cmd.valid && (cmd.read || cmd.read_auto_close) && readout_mode;
   // beat parity is enough: both nibbles of the pattern start on an even beat
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_pipe_r <= 32'h0;
         beat_r    <= 3'h0;
         loc_r     <= 2'h0;
      end
      else
      begin
         rd_pipe_r <= {rd_pipe_r[30:0], rd};
         beat_r    <= lane_data_oe ? beat_r + 3'h1 : 3'h0;
         loc_r     <= (ms && cmd.reg_sel == 2'h3) ? cmd.addr[1:0] : loc_r;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_readout_on: assert property (ms && cmd.reg_sel == 2'h3 && cmd.addr[2] |=> readout_mode)
      else $error("readout mode not entered");
   a_readout_off: assert property (ms && cmd.reg_sel == 2'h3 && !cmd.addr[2] |=> !readout_mode)
      else $error("readout mode not left");
   a_level_on: assert property (ms && cmd.reg_sel == 2'h1 && cmd.addr[7] |=> level_mode)
      else $error("leveling mode not entered");
   a_gap_then_allowed: assert property (ms |=> !cmd_allowed ##4 cmd_allowed)
      else $error("command allowance not timed by update delay");
   a_undef_exit: assert property (ms && cmd.reg_sel == 2'h1 && !cmd.addr[7] && level_mode
      |=> data_undefined [*4] ##1 !data_undefined)
      else $error("undefined window wrong after leveling exit");
   a_array_quiet: assert property (readout_mode && $past(readout_mode) |-> !array_read && !array_write)
      else $error("array accessed in readout mode");
   a_skip_close: assert property (rd && cmd.read_auto_close |=> skip_auto_close)
      else $error("auto close not suppressed");
   a_oe_latency: assert property (rd_pipe_r[READ_LATENCY+1] |-> lane_data_oe)
      else $error("burst not at read latency");
   a_oe_cause: assert property ($rose(lane_data_oe) && readout_mode |-> rd_pipe_r[READ_LATENCY+1])
      else $error("burst without read");
   a_pattern_bits: assert property (lane_data_oe && readout_mode
      |-> lower_lane_data[0] == (loc_r == 2'h0 && beat_r[0]))
      else $error("pattern bit wrong");
   a_lane_copy: assert property (lane_data_oe && readout_mode |-> upper_lane_data == lower_lane_data
      && lower_lane_data == (COPY_UPPER ? {8{lower_lane_data[0]}} : {7'h0, lower_lane_data[0]}))
      else $error("lane bits not copied");
   a_level_quiet: assert property (level_mode && lane_data_oe && !data_undefined |-> FEEDBACK_ALL
      || (lower_lane_data[7:1] == 7'h0 && upper_lane_data[7:1] == 7'h0))
      else $error("non prime feedback pins not low");
   c_read: cover property (rd && cmd.read);
   c_read_close: cover property (rd && cmd.read_auto_close);
   c_level_exit: cover property ($rose(data_undefined));
endmodule
bind calib_readout calib_readout_sva #(.READ_LATENCY(READ_LATENCY), .FEEDBACK_ALL(FEEDBACK_ALL),
   .COPY_UPPER(COPY_UPPER)) u_sva (.core_clk(core_clk), .arst_n(arst_n), .cmd(cmd),
   .lower_lane_data(lower_lane_data), .upper_lane_data(upper_lane_data),
   .lane_data_oe(lane_data_oe), .data_undefined(data_undefined), .level_mode(level_mode),
   .readout_mode(readout_mode), .array_read(array_read), .array_write(array_write),
   .skip_auto_close(skip_auto_close), .cmd_allowed(cmd_allowed));

// ### tb/strobe_ctl_model.sv
// model: controller side of the strobe pairs and clock level during leveling
// assumes fire is a one-cycle request from the bench
`timescale 1ns/10ps
module strobe_ctl_model (
   input  wire logic core_clk,
   input  wire logic fire,
   input  wire logic clk_level,
   output logic      lower_strobe_pin,
   output logic      upper_strobe_pin,
   output logic      lower_clk_sample,
   output logic      upper_clk_sample
);
   int ph = 0;
   always @(posedge core_clk)
   begin
      if (fire)
         ph <= 4;
      else if (ph != 0)
         ph <= ph - 1;
   end
   // two cycles low then two high, above both pulse minimums
   // back to idle low after the single rise: the pair stays driven low
   assign lower_strobe_pin = (ph == 2 || ph == 1);
   assign upper_strobe_pin = (ph == 2 || ph == 1);
   assign lower_clk_sample = clk_level;
   assign upper_clk_sample = clk_level;
endmodule

// ### tb/calib_readout_tb.sv
// testbench: leveling feedback and exit, calibration bursts, normal array access
// assumes calib_readout with its bound checker and the strobe model
`timescale 1ns/10ps
module calib_readout_tb;
   localparam int RL = 6;
   logic                       core_clk = 1'b0;
   logic                       arst_n = 1'b0;
   calib_readout_pkg::cmd_type cmd = '0;
   logic                       fire = 1'b0;
   logic                       clk_level = 1'b0;
   logic                       ls, us, lc, uc, oe, undef, lvl, rdm, ard, awr, skip, allowed;
   logic [7:0]                 lo, up;
   int                         fails = 0;
   int                         tests_run = 0;
   always #2 core_clk = ~core_clk;
   calib_readout #(.READ_LATENCY(RL)) DUT (.core_clk(core_clk), .arst_n(arst_n), .cmd(cmd),
      .lower_strobe_pin(ls), .upper_strobe_pin(us), .lower_clk_sample(lc),
      .upper_clk_sample(uc), .lower_lane_data(lo), .upper_lane_data(up), .lane_data_oe(oe),
      .data_undefined(undef), .level_mode(lvl), .readout_mode(rdm), .array_read(ard),
      .array_write(awr), .skip_auto_close(skip), .cmd_allowed(allowed));
   strobe_ctl_model u_model (.core_clk(core_clk), .fire(fire), .clk_level(clk_level),
      .lower_strobe_pin(ls), .upper_strobe_pin(us), .lower_clk_sample(lc),
      .upper_clk_sample(uc));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // kind bits: mode set, read, read with auto close, write
   task automatic send(input logic [3:0] kind, input logic [1:0] sel, input logic [14:0] addr);
      @(posedge core_clk) #1;
      cmd = {1'b1, kind, sel, addr};
      @(posedge core_clk) #1;
      cmd = '0;
   endtask
   task automatic wait_allowed;
      for (int i = 0; i < 50 && allowed !== 1'b1; i++)
         @(posedge core_clk) #1;
      check("cmd_allowed", {7'h0, allowed}, 8'h01);
      if (allowed !== 1'b1)
         tally_and_finish();
   endtask
   task automatic burst(input logic [14:0] addr, input logic rac, input int n);
      int i;
      int base;
      base = (n == 4 && addr[2]) ? 4 : 0;
      send(rac ? 4'h2 : 4'h4, 2'h0, addr);
      check("skip_close", {7'h0, skip}, {7'h0, rac});
      check("array_read", {7'h0, ard}, 8'h00);
      for (i = 0; i < 20 && oe !== 1'b1; i++)
         @(posedge core_clk) #1;
      check("latency", 8'(i), 8'(RL + 1));
      if (oe !== 1'b1)
         tally_and_finish();
      for (i = 0; i < n; i++)
      begin
         check("lower", lo, {8{calib_readout_pkg::PATTERN_BITS[base + i]}});
         check("upper", up, {8{calib_readout_pkg::PATTERN_BITS[base + i]}});
         @(posedge core_clk) #1;
      end
      check("burst_end", {7'h0, oe}, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge core_clk);
      #1 arst_n = 1'b1;
      send(4'h8, 2'h1, 15'h0080);
      check("level_on", {7'h0, lvl}, 8'h01);
      wait_allowed();
      for (int k = 0; k < 2; k++)
      begin
         clk_level = k[0];
         fire = 1'b1;
         @(posedge core_clk) #1;
         fire = 1'b0;
         repeat (12) @(posedge core_clk);
         #1;
         check("fb_lower", lo, {7'h0, k[0]});
         check("fb_upper", up, {7'h0, k[0]});
      end
      // strobes idle and held low before the exit
      send(4'h8, 2'h1, 15'h0000);
      check("undef_on", {7'h0, undef}, 8'h01);
      check("level_off", {7'h0, lvl}, 8'h00);
      wait_allowed();
      check("undef_off", {7'h0, undef}, 8'h00);
      send(4'h4, 2'h0, 15'h0000);
      check("array_rd", {7'h0, ard}, 8'h01);
      send(4'h1, 2'h0, 15'h0000);
      check("array_wr", {7'h0, awr}, 8'h01);
      send(4'h8, 2'h0, 15'h0001);
      wait_allowed();
      // no array access pending, so every bank is idle here
      send(4'h8, 2'h3, 15'h0004);
      check("readout_on", {7'h0, rdm}, 8'h01);
      wait_allowed();
      // three reads then a refused write, column bits 1:0 zero
      burst(15'h7FF8, 1'b0, 8);
      burst(15'h6FF8, 1'b1, 4);
      burst(15'h6FFC, 1'b0, 4);
      send(4'h1, 2'h0, 15'h0000);
      check("write_refused", {7'h0, awr}, 8'h00);
      repeat (8) @(posedge core_clk);
      send(4'h8, 2'h3, 15'h0000);
      check("readout_off", {7'h0, rdm}, 8'h00);
      wait_allowed();
      send(4'h4, 2'h0, 15'h0000);
      check("array_back", {7'h0, ard}, 8'h01);
      send(4'h8, 2'h3, 15'h0004);
      wait_allowed();
      arst_n = 1'b0;
      @(posedge core_clk) #1;
      check("reset_mode", {7'h0, rdm}, 8'h00);
      arst_n = 1'b1;
      tally_and_finish();
   end
endmodule
